// [design/flash_suspend_command_gate.sv]
`timescale 1ns/1ps
`include "flash_suspend_consts.svh"
module flash_suspend_command_gate
    import flash_suspend_pkg::*;
#(
    parameter int SUSPEND_INDICATOR_LAT = `SUSPEND_INDICATOR_LAT_CYC
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // spi pins
    input wire logic spiClk,
    input wire logic chipSel_n,
    input wire logic serialIn,
    // internal operation engine
    input wire logic opStart,
    input wire logic [7:0] opOpcode,
    input wire logic opDone,
    input wire logic wenSet,
    input wire logic wenClr,
    // outputs
    output status_type status,
    output cmd_type accepted,
    output logic opHalt,
    output logic opResume
);
    // the halt check below spans the whole latency, so it is kept within a checkable reach
    if (SUSPEND_INDICATOR_LAT < 1 || SUSPEND_INDICATOR_LAT > 1000)
    begin : g_badLat
        $error("SUSPEND_INDICATOR_LAT must lie between 1 and 1000 cycles");
    end

    logic rstS1_r, rst_n;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            rstS1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rstS1_r <= 1'b1;
            rst_n <= rstS1_r;
        end

    // pins pass two flops; only the second stage is read
    logic [2:0] pinA_r, pinB_r;
    logic sclkD_r;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            pinA_r <= 3'h1;
            pinB_r <= 3'h1;
            sclkD_r <= 1'b0;
        end
        else
        begin
            pinA_r <= {spiClk, serialIn, chipSel_n};
            pinB_r <= pinA_r;
            sclkD_r <= pinB_r[2];
        end
    wire logic csN = pinB_r[0];
    wire logic sdi = pinB_r[1];
    wire logic sclkRise = pinB_r[2] & ~sclkD_r;

    logic csD_r;
    logic [7:0] shift_r, shift_nxt;
    logic [5:0] bits_r, bits_nxt;
    logic [7:0] first_r, first_nxt;
    status_type st_r, st_nxt;
    opKind_type kind_r, kind_nxt, heldKind_r, heldKind_nxt;
    cmd_type acc_r, acc_nxt;
    logic [15:0] lat_r, lat_nxt;
    logic halt_r, halt_nxt, res_r, res_nxt;

    function automatic logic inSet(input logic [7:0] o, input status_type s);
        logic always_ok;
        logic suspend_indicator_ok;
        always_ok = o inside {`OP_RDSR1, `OP_RDSR2, `OP_RDSR3, `OP_RDSRI, `OP_TERM, `OP_RSTEN,
                              `OP_RST, `OP_ID1, `OP_ID2, `OP_ID3, `OP_WAKE};
        suspend_indicator_ok = o inside {`OP_RES_A, `OP_RES_B, `OP_WREN, `OP_WRDI, `OP_VWREN, `OP_LKRD1, `OP_LKRD2,
                            `OP_OTPRD, `OP_SFDP, `OP_WRAP, `OP_RD1, `OP_RD2, `OP_RD3, `OP_RD4,
                            `OP_RD5, `OP_RD6};
        if (s.busyFlag)
            inSet = always_ok | (o inside {`OP_SUSPEND_INDICATOR_A, `OP_SUSPEND_INDICATOR_B});
        else if (s.programSuspendedFlag)
            inSet = always_ok | suspend_indicator_ok;
        else if (s.eraseSuspendedFlag)
            inSet = always_ok | suspend_indicator_ok | (o inside {`OP_PP1, `OP_PP2, `OP_PP3, `OP_SEQ1, `OP_SEQ2});
        else
            inSet = 1'b1;
    endfunction

    always_comb
    begin
        shift_nxt = shift_r;
        bits_nxt = bits_r;
        first_nxt = first_r;
        st_nxt = st_r;
        kind_nxt = kind_r;
        heldKind_nxt = heldKind_r;
        acc_nxt = '0;
        lat_nxt = lat_r;
        halt_nxt = 1'b0;
        res_nxt = 1'b0;
        if (!csN && sclkRise)
        begin
            shift_nxt = {shift_r[6:0], sdi};
            // past the first byte only the position in the byte matters, so long frames never saturate
            bits_nxt = (bits_r[5:3] != 3'h0) ? {3'h1, bits_r[2:0] + 3'h1} : bits_r + 6'h01;
            if (bits_r == 6'h07)
                first_nxt = {shift_r[6:0], sdi};
        end
        // frame end: act only on whole bytes with a full opcode
        if (csN && !csD_r)
        begin
            bits_nxt = '0;
            if (bits_r >= 6'h08 && bits_r[2:0] == 3'h0 && inSet(first_r, st_r))
            begin
                acc_nxt = '{valid: 1'b1, opcode: first_r};
                if (first_r inside {`OP_SUSPEND_INDICATOR_A, `OP_SUSPEND_INDICATOR_B})
                begin
                    if (kind_r == OP_ERASE || kind_r == OP_PROGRAM)
                        lat_nxt = 16'(SUSPEND_INDICATOR_LAT);
                end
                else if (first_r inside {`OP_RES_A, `OP_RES_B})
                begin
                    if (!st_r.busyFlag && (st_r.programSuspendedFlag || st_r.eraseSuspendedFlag))
                    begin
                        res_nxt = 1'b1;
                        st_nxt.busyFlag = 1'b1;
                        if (st_r.programSuspendedFlag)
                        begin
                            st_nxt.programSuspendedFlag = 1'b0;
                            kind_nxt = OP_PROGRAM;
                        end
                        else
                        begin
                            st_nxt.eraseSuspendedFlag = 1'b0;
                            kind_nxt = heldKind_r;
                        end
                        st_nxt.suspendIndicator = st_r.programSuspendedFlag & st_r.eraseSuspendedFlag;
                    end
                end
                else if (first_r == `OP_WREN)
                    st_nxt.writeEnableLatch = 1'b1;
                else if (first_r == `OP_WRDI)
                    st_nxt.writeEnableLatch = 1'b0;
            end
        end
        if (wenClr)
            st_nxt.writeEnableLatch = 1'b0;
        if (wenSet)
            st_nxt.writeEnableLatch = 1'b1;
        if (opStart && !st_r.busyFlag)
        begin
            st_nxt.busyFlag = 1'b1;
            if (opOpcode inside {`OP_BE1, `OP_BE2, `OP_BE3})
                kind_nxt = OP_ERASE;
            else if (opOpcode inside {`OP_PP1, `OP_PP2, `OP_PP3})
                kind_nxt = OP_PROGRAM;
            else
                kind_nxt = OP_LOCKED;
        end
        if (lat_r != 16'h0)
        begin
            lat_nxt = lat_r - 16'h1;
            if (lat_r == 16'h1 || opDone)
            begin
                lat_nxt = '0;
                halt_nxt = 1'b1;
                st_nxt.busyFlag = 1'b0;
                st_nxt.suspendIndicator = 1'b1;
                if (kind_r == OP_ERASE)
                begin
                    st_nxt.eraseSuspendedFlag = 1'b1;
                    heldKind_nxt = OP_ERASE;
                end
                else
                    st_nxt.programSuspendedFlag = 1'b1;
                kind_nxt = OP_NONE;
            end
        end
        else if (opDone && st_r.busyFlag)
        begin
            st_nxt.busyFlag = 1'b0;
            kind_nxt = OP_NONE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            csD_r <= 1'b1;
            shift_r <= '0;
            bits_r <= '0;
            first_r <= '0;
            st_r <= '0;
            kind_r <= OP_NONE;
            heldKind_r <= OP_NONE;
            acc_r <= '0;
            lat_r <= '0;
            halt_r <= 1'b0;
            res_r <= 1'b0;
        end
        else
        begin
            csD_r <= csN;
            shift_r <= shift_nxt;
            bits_r <= bits_nxt;
            first_r <= first_nxt;
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            heldKind_r <= heldKind_nxt;
            acc_r <= acc_nxt;
            lat_r <= lat_nxt;
            halt_r <= halt_nxt;
            res_r <= res_nxt;
        end

    assign status = st_r;
    assign accepted = acc_r;
    assign opHalt = halt_r;
    assign opResume = res_r;

    a_halt_clears_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        halt_r |-> !st_r.busyFlag && st_r.suspendIndicator)
        else $error("halt without busy clear");
    a_halt_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        halt_r |-> (st_r.eraseSuspendedFlag || st_r.programSuspendedFlag))
        else $error("halt without suspended flag");
    a_latency_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(lat_r != 16'h0) |-> ##[1:SUSPEND_INDICATOR_LAT] halt_r)
        else $error("suspend latency exceeded");
    a_locked_no_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
        kind_r == OP_LOCKED |-> lat_r == 16'h0 && !halt_r)
        else $error("locked operation suspended");
    a_no_erase_psusp: assert property (@(posedge core_clk) disable iff (!rst_n)
        acc_r.valid && $past(st_r.programSuspendedFlag) && !$past(st_r.busyFlag)
        |-> !(acc_r.opcode inside {`OP_BE1, `OP_BE2, `OP_BE3, `OP_CE1, `OP_CE2}))
        else $error("erase accepted in program suspend");
    a_busy_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
        acc_r.valid && $past(st_r.busyFlag) |-> !(acc_r.opcode inside {`OP_WREN, `OP_PP1, `OP_BE1, `OP_WRSR1}))
        else $error("command accepted while busy");
    a_resume_sets_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        res_r |-> st_r.busyFlag && $past(st_r.busyFlag) == 1'b0)
        else $error("resume without busy set");
    a_refused_keeps_wel: assert property (@(posedge core_clk) disable iff (!rst_n)
        (csN && !csD_r && !inSet(first_r, st_r) && !wenSet && !wenClr)
        |=> st_r.writeEnableLatch == $past(st_r.writeEnableLatch))
        else $error("refused command touched write enable");
endmodule // flash_suspend_command_gate

// [design/flash_suspend_consts.svh]
`ifndef FLASH_SUSPEND_CONSTS_SVH
`define FLASH_SUSPEND_CONSTS_SVH
// opcodes
`define OP_SUSPEND_INDICATOR_A 8'h75
`define OP_SUSPEND_INDICATOR_B 8'hb0
`define OP_RES_A 8'h7a
`define OP_RES_B 8'hd0
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_RDSRI 8'h65
`define OP_TERM 8'hf0
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_ID1 8'h9f
`define OP_ID2 8'h90
`define OP_ID3 8'h94
`define OP_WAKE 8'hab
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_VWREN 8'h50
`define OP_LKRD1 8'h3c
`define OP_LKRD2 8'h3d
`define OP_OTPRD 8'h4b
`define OP_SFDP 8'h5a
`define OP_WRAP 8'h77
`define OP_RD1 8'h03
`define OP_RD2 8'h0b
`define OP_RD3 8'h3b
`define OP_RD4 8'h6b
`define OP_RD5 8'heb
`define OP_RD6 8'he7
`define OP_PP1 8'h02
`define OP_PP2 8'ha2
`define OP_PP3 8'h32
`define OP_SEQ1 8'had
`define OP_SEQ2 8'haf
`define OP_BE1 8'h20
`define OP_BE2 8'h52
`define OP_BE3 8'hd8
`define OP_CE1 8'h60
`define OP_CE2 8'hc7
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_WRSRI 8'h71
`define OP_SRLK 8'h6f
`define OP_OTPPG 8'h9b
// suspend latency in ns, and cycles at 40 MHz (longest time, rounded down)
`define SUSPEND_INDICATOR_LAT_NS 20000
`define CLK_NS 25
`define SUSPEND_INDICATOR_LAT_CYC (`SUSPEND_INDICATOR_LAT_NS / `CLK_NS)
`endif

// [design/flash_suspend_pkg.sv]
package flash_suspend_pkg;
    typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROGRAM, OP_LOCKED} opKind_type;
    typedef struct packed {
        logic busyFlag;
        logic suspendIndicator;
        logic programSuspendedFlag;
        logic eraseSuspendedFlag;
        logic writeEnableLatch;
    } status_type;
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
    } cmd_type;
endpackage

// [verif/flash_suspend_command_gate_tb.sv]
`timescale 1ns/1ps
module flash_suspend_command_gate_tb;
    import flash_suspend_pkg::*;
    localparam int LAT = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic opStart = 1'b0;
    logic opDone = 1'b0;
    logic wenSet = 1'b0;
    logic wenClr = 1'b0;
    logic [7:0] opOpcode = 8'h00;
    logic go = 1'b0;
    logic [7:0] op = 8'h00;
    logic [4:0] nBits = 5'h08;
    logic hostBusy, spiClk, chipSel_n, serialIn, opHalt, opResume;
    status_type status;
    cmd_type accepted;
    logic [7:0] lastOp;
    int fail_count = 0;
    int comparisons = 0;
    int accCnt = 0;
    int haltCnt = 0;
    int resCnt = 0;
    logic [7:0] esNo[8] = '{8'h36, 8'h9b, 8'h01, 8'h71, 8'h6f, 8'hb9, 8'h79, 8'h75};
    logic [7:0] psYes[8] = '{8'h3c, 8'h3d, 8'h4b, 8'h5a, 8'h77, 8'h06, 8'h50, 8'h04};
    logic [7:0] psNo[10] = '{8'h20, 8'h52, 8'h60, 8'h02, 8'had, 8'h01, 8'h6f, 8'hb9, 8'h75, 8'hb0};
    logic [7:0] fixed[10] = '{8'h60, 8'hc7, 8'h9b, 8'had, 8'haf, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6f};
    logic [7:0] busyYes[11] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hab};

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    flash_suspend_command_gate #(.SUSPEND_INDICATOR_LAT(LAT)) u_flash_suspend_command_gate (.core_clk(core_clk),
        .arst_n(arst_n), .spiClk(spiClk), .chipSel_n(chipSel_n), .serialIn(serialIn), .opStart(opStart),
        .opOpcode(opOpcode), .opDone(opDone), .wenSet(wenSet), .wenClr(wenClr), .status(status),
        .accepted(accepted), .opHalt(opHalt), .opResume(opResume));
    spi_host_model u_spi_host_model (.core_clk(core_clk), .go(go), .opcode(op), .nBits(nBits),
        .busy(hostBusy), .spiClk(spiClk), .chipSel_n(chipSel_n), .serialIn(serialIn));

    // pulses counted on the falling edge, away from the launching edge
    always @(negedge core_clk)
    begin
        if (accepted.valid === 1'b1)
        begin
            accCnt++;
            lastOp = accepted.opcode;
        end
        if (opHalt === 1'b1)
            haltCnt++;
        if (opResume === 1'b1)
            resCnt++;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // engine event: 0 start, 1 done, 2 latch set, 3 latch clear
    task automatic ev(input int which, input logic [7:0] c, input logic [4:0] e);
        opOpcode <= c;
        {opStart, opDone, wenSet, wenClr} <= 4'(8 >> which);
        @(posedge core_clk);
        {opStart, opDone, wenSet, wenClr} <= 4'h0;
        repeat (4) @(posedge core_clk);
        check("status", {3'h0, e}, 8'(status));
    endtask

    // latch bit masked here: write enable commands may move it
    task automatic cmd(input logic [7:0] c, input logic [4:0] nb, input int acc, input int hlt, input int res,
        input logic [4:0] e);
        int a0, h0, r0;
        a0 = accCnt;
        h0 = haltCnt;
        r0 = resCnt;
        op <= c;
        nBits <= nb;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 300 && hostBusy; k++)
            @(posedge core_clk);
        repeat (LAT + 16) @(posedge core_clk);
        check("accepted", 8'(acc), 8'(accCnt - a0));
        check("halt", 8'(hlt), 8'(haltCnt - h0));
        check("resume", 8'(res), 8'(resCnt - r0));
        if (acc != 0)
            check("opcode", c, lastOp);
        check("status", {3'h0, e} & 8'h1e, 8'(status) & 8'h1e);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #400000;
        fail_count++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        check("reset status", 8'h00, 8'(status));
        ev(0, 8'h20, 5'h10);
        cmd(8'h05, 8, 1, 0, 0, 5'h10);
        cmd(8'h06, 8, 0, 0, 0, 5'h10);
        check("latch", 8'h00, {7'h0, status.writeEnableLatch});
        cmd(8'h75, 8, 1, 1, 0, 5'h0a);
        cmd(8'h03, 8, 1, 0, 0, 5'h0a);
        foreach (esNo[i]) cmd(esNo[i], 8, 0, 0, 0, 5'h0a);
        ev(0, 8'h02, 5'h1a);
        cmd(8'hb0, 8, 1, 1, 0, 5'h0e);
        foreach (psYes[i]) cmd(psYes[i], 8, 1, 0, 0, 5'h0e);
        ev(2, 8'h00, 5'h0f);
        foreach (psNo[i]) cmd(psNo[i], 8, 0, 0, 0, 5'h0e);
        check("latch", 8'h01, {7'h0, status.writeEnableLatch});
        cmd(8'h7a, 8, 1, 0, 1, 5'h1a);
        ev(1, 8'h00, 5'h0b);
        cmd(8'hd0, 8, 1, 0, 1, 5'h11);
        ev(1, 8'h00, 5'h01);
        ev(3, 8'h00, 5'h00);
        cmd(8'h7a, 8, 1, 0, 0, 5'h00);
        $display("test nested suspend done");
        foreach (fixed[i])
        begin
            ev(0, fixed[i], 5'h10);
            cmd(8'h75, 8, 1, 0, 0, 5'h10);
            ev(1, 8'h00, 5'h00);
        end
        $display("test fixed operations done");
        ev(0, 8'hd8, 5'h10);
        foreach (busyYes[i]) cmd(busyYes[i], 8, 1, 0, 0, 5'h10);
        cmd(8'h75, 7, 0, 0, 0, 5'h10);
        cmd(8'hb0, 12, 0, 0, 0, 5'h10);
        cmd(8'h7a, 8, 0, 0, 0, 5'h10);
        ev(1, 8'h00, 5'h00);
        $display("test busy gating done");
        close_out();
    end
endmodule // flash_suspend_command_gate_tb

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input wire logic core_clk,
    // request from the bench
    input wire logic go,
    input wire logic [7:0] opcode,
    input wire logic [4:0] nBits,
    output logic busy,
    // spi pins
    output logic spiClk,
    output logic chipSel_n,
    output logic serialIn
);
    initial
    begin
        busy = 1'b0;
        spiClk = 1'b0;
        chipSel_n = 1'b1;
        serialIn = 1'b0;
    end

    // clock stands low between frames; 4 core cycles per half keeps the sync margin
    always @(posedge core_clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            chipSel_n <= 1'b0;
            for (int i = 0; i < nBits; i++)
            begin
                serialIn <= opcode[7 - (i % 8)];
                repeat (4) @(posedge core_clk);
                spiClk <= 1'b1;
                repeat (4) @(posedge core_clk);
                spiClk <= 1'b0;
            end
            serialIn <= ~serialIn;
            repeat (4) @(posedge core_clk);
            chipSel_n <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule // spi_host_model
